// ---- include/asu_pkg.sv ----
// Package for the asynchronous serial transceiver core.
// Assumes a 32-bit APB master on pclk and a 10 MHz clock.
package asu_pkg;
  localparam logic [11:0] ASU_OFF_TX = 12'h000;
  localparam logic [11:0] ASU_OFF_RX = 12'h004;
  localparam logic [11:0] ASU_OFF_MODE = 12'h008;
  localparam logic [11:0] ASU_OFF_ERR = 12'h00C;
  localparam logic [11:0] ASU_OFF_BAUD = 12'h010;
  localparam logic [11:0] ASU_OFF_PIN = 12'h014;
  localparam logic [11:0] ASU_OFF_EVT = 12'h018;
  localparam logic [7:0] ASU_TX_RST = 8'hFF;
  localparam logic [7:0] ASU_RX_RST = 8'h00;
  localparam logic [7:0] ASU_MODE_RST = 8'h00;
  localparam logic [7:0] ASU_BAUD_RST = 8'h10;
  localparam int ASU_MODE_TXE = 7;
  localparam int ASU_MODE_RXE = 6;
  localparam int ASU_MODE_LEN8 = 5;
  localparam int ASU_MODE_EXTCLK = 2;
  localparam int ASU_MODE_ERRMASK = 1;
  localparam logic [7:0] ASU_MODE_MASK = 8'hE6;
  localparam int ASU_ERR_FRAME = 0;
  localparam int ASU_ERR_OVERRUN = 1;
  localparam int ASU_ERR_NOISE = 2;
  localparam logic [3:0] ASU_K_BASE = 4'h0;
  localparam logic [4:0] ASU_K_OFFSET = 5'h10;
  localparam logic [3:0] ASU_MID_TICK = 4'h8;
  localparam logic [3:0] ASU_LAST_TICK = 4'hF;

  typedef enum logic [1:0] {
    ASU_IDLE = 2'b00,
    ASU_START = 2'b01,
    ASU_DATA = 2'b10,
    ASU_STOP = 2'b11
  } asu_phase_t;

  typedef struct packed {
    asu_phase_t ph;
    logic [3:0] tick;
    logic [2:0] bitn;
    logic [7:0] sh;
  } asu_serial_t;

  typedef struct packed {
    logic [7:0] tx_shift;
    logic [7:0] rx_buf;
    logic [7:0] mode;
    logic [2:0] err;
    logic [7:0] baud;
    logic evt_opt;
    logic [7:0] pre;
    logic [4:0] kcnt;
    logic [2:0] ext_sync;
    asu_serial_t tx;
    asu_serial_t rx;
    logic [1:0] rx_sync;
    logic txd;
    logic txd_oe;
    logic rxd_sel;
    logic rx_done;
    logic tx_done;
    logic [31:0] prdata;
  } asu_state_t;
endpackage

// ---- hw/asu_core.sv ----
// Asynchronous serial transceiver with APB register access.
// Assumes APB master on pclk; rxd and baud_clk_pin are asynchronous pins.
// Functional notes
// - Full duplex: one character after a start bit each way.
// - Baud tick from internal generator or divided external baud clock pin.
// - Writing the transmit register starts a frame when transmit is enabled and the transmitter is idle.
// - Seven-bit mode sends only bits zero to six.
// - Transmit register write-only byte, reads zero, resets to all ones.
// - Completed character copied into the receive buffer.
// - Seven-bit mode fills bits zero to six, top bit zero.
// - Receive buffer read-only, ignores writes, resets to zero.
// - Receive deserialiser builds the character, not software visible.
// - Mode register byte writable, implemented bits reset to zero.
// - Bit 7 transmit enable, bit 6 receive enable; both off frees pins.
// - Receive only with option clear makes rx pin serial input.
// - Transmit only makes tx pin serial output regardless of option.
// - Both enabled with option clear assigns both pins to serial.
// - Status register reports framing error in bit 0; bit 1 copies the previous receive-complete pulse, bit 2 reads zero.
// - Receiver samples rx pin with the selected serial clock.
// - Receive-complete pulse each frame; data stored even on error.
// - Mode bit 1 suppresses receive-complete on errored frames.
// - Baud tick equals source over (two to the n, plus one) times (k plus sixteen).
`timescale 1ns/1ps
module asu_core
  import asu_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd,
  input wire logic baud_clk_pin,
  output logic txd,
  output logic txd_oe,
  output logic rxd_sel,
  // Events
  output logic rx_done,
  output logic tx_done
);
  asu_state_t s_r;
  asu_state_t s_nxt;
  logic wr;
  logic rd;
  logic tick16;
  logic ext_rise;
  logic [2:0] n_sel;
  logic [3:0] k_sel;
  logic len8;
  logic rxs;
  logic err_frame;

  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign txd = s_r.txd;
  assign txd_oe = s_r.txd_oe;
  assign rxd_sel = s_r.rxd_sel;
  assign rx_done = s_r.rx_done;
  assign tx_done = s_r.tx_done;

  always_comb
  begin
    s_nxt = s_r;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    n_sel = s_r.baud[6:4];
    k_sel = s_r.baud[3:0];
    len8 = s_r.mode[ASU_MODE_LEN8];
    rxs = s_r.rx_sync[1];
    tick16 = 1'b0;
    err_frame = 1'b0;
    s_nxt.rx_done = 1'b0;
    s_nxt.tx_done = 1'b0;
    // Pin synchronisers; rx reads the second stage, the baud clock edge uses stages two and three
    s_nxt.rx_sync = {s_r.rx_sync[0], rxd};
    s_nxt.ext_sync = {s_r.ext_sync[1:0], baud_clk_pin};
    ext_rise = s_r.ext_sync[1] && !s_r.ext_sync[2];
    // Prescaler 2^n+1 on chosen source, then k+16 divider
    if (!s_r.mode[ASU_MODE_EXTCLK] || ext_rise)
    begin
      s_nxt.pre = s_r.pre + 8'h01;
      if (s_r.pre[n_sel])
      begin
        s_nxt.pre = 8'h00;
        s_nxt.kcnt = s_r.kcnt + 5'h01;
        if (s_r.kcnt >= (ASU_K_OFFSET + {1'b0, k_sel} - 5'h01))
        begin
          s_nxt.kcnt = 5'h00;
          tick16 = 1'b1;
        end
      end
    end
    // Pin assignment
    s_nxt.txd_oe = s_r.mode[ASU_MODE_TXE];
    s_nxt.rxd_sel = s_r.mode[ASU_MODE_RXE] && !s_r.evt_opt;
    // Transmitter: 16 ticks per bit
    if (tick16)
    begin
      case (s_r.tx.ph)
        ASU_IDLE: s_nxt.txd = 1'b1;
        ASU_START:
        begin
          s_nxt.txd = 1'b0;
          s_nxt.tx.tick = s_r.tx.tick + 4'h1;
          if (s_r.tx.tick == ASU_LAST_TICK)
            s_nxt.tx.ph = ASU_DATA;
        end
        ASU_DATA:
        begin
          s_nxt.txd = s_r.tx.sh[0];
          s_nxt.tx.tick = s_r.tx.tick + 4'h1;
          if (s_r.tx.tick == ASU_LAST_TICK)
          begin
            s_nxt.tx.sh = {1'b1, s_r.tx.sh[7:1]};
            s_nxt.tx.bitn = s_r.tx.bitn + 3'h1;
            if (s_r.tx.bitn == (len8 ? 3'h7 : 3'h6))
              s_nxt.tx.ph = ASU_STOP;
          end
        end
        ASU_STOP:
        begin
          s_nxt.txd = 1'b1;
          s_nxt.tx.tick = s_r.tx.tick + 4'h1;
          if (s_r.tx.tick == ASU_LAST_TICK)
          begin
            s_nxt.tx.ph = ASU_IDLE;
            s_nxt.tx_done = 1'b1;
          end
        end
        default: s_nxt.tx.ph = ASU_IDLE;
      endcase
    end
    // Receiver: detect start, sample mid bit
    if (!s_r.mode[ASU_MODE_RXE])
      s_nxt.rx.ph = ASU_IDLE;
    else if (tick16)
    begin
      s_nxt.rx.tick = s_r.rx.tick + 4'h1;
      case (s_r.rx.ph)
        ASU_IDLE:
        begin
          s_nxt.rx.tick = 4'h0;
          if (!rxs)
          begin
            s_nxt.rx.ph = ASU_START;
            s_nxt.rx.tick = 4'h1;
          end
        end
        ASU_START:
          if (s_r.rx.tick == ASU_MID_TICK)
          begin
            s_nxt.rx.tick = 4'h1;
            s_nxt.rx.bitn = 3'h0;
            s_nxt.rx.ph = rxs ? ASU_IDLE : ASU_DATA;
          end
        ASU_DATA:
          if (s_r.rx.tick == 4'h0)
          begin
            s_nxt.rx.sh = {rxs, s_r.rx.sh[7:1]};
            s_nxt.rx.bitn = s_r.rx.bitn + 3'h1;
            if (s_r.rx.bitn == (len8 ? 3'h7 : 3'h6))
              s_nxt.rx.ph = ASU_STOP;
          end
        ASU_STOP:
          if (s_r.rx.tick == 4'h0)
          begin
            s_nxt.rx.ph = ASU_IDLE;
            err_frame = !rxs;
            s_nxt.rx_buf = len8 ? s_r.rx.sh : {1'b0, s_r.rx.sh[7:1]};
            s_nxt.err = {1'b0, s_r.rx_done, err_frame};
            s_nxt.rx_done = !(err_frame && s_r.mode[ASU_MODE_ERRMASK]);
          end
        default: s_nxt.rx.ph = ASU_IDLE;
      endcase
    end
    // Register writes
    if (wr)
    begin
      case (paddr)
        ASU_OFF_TX:
        begin
          s_nxt.tx_shift = pwdata[7:0];
          if (s_r.mode[ASU_MODE_TXE] && s_r.tx.ph == ASU_IDLE)
          begin
            s_nxt.tx.sh = pwdata[7:0];
            s_nxt.tx.ph = ASU_START;
            s_nxt.tx.tick = 4'h0;
            s_nxt.tx.bitn = 3'h0;
          end
        end
        ASU_OFF_MODE: s_nxt.mode = pwdata[7:0] & ASU_MODE_MASK;
        ASU_OFF_BAUD: s_nxt.baud = pwdata[7:0];
        ASU_OFF_PIN: s_nxt.evt_opt = pwdata[0];
        default: s_nxt.mode = s_nxt.mode;
      endcase
    end
    // Read data captured in setup cycle
    if (rd)
    begin
      case (paddr)
        ASU_OFF_RX: s_nxt.prdata = {24'h000000, s_r.rx_buf};
        ASU_OFF_MODE: s_nxt.prdata = {24'h000000, s_r.mode};
        ASU_OFF_ERR: s_nxt.prdata = {29'h00000000, s_r.err};
        ASU_OFF_BAUD: s_nxt.prdata = {24'h000000, s_r.baud};
        ASU_OFF_PIN: s_nxt.prdata = {31'h00000000, s_r.evt_opt};
        ASU_OFF_EVT: s_nxt.prdata = {30'h00000000, s_r.tx.ph != ASU_IDLE,
                                     s_r.rx.ph != ASU_IDLE};
        default: s_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.tx_shift <= ASU_TX_RST;
      s_r.rx_buf <= ASU_RX_RST;
      s_r.mode <= ASU_MODE_RST;
      s_r.baud <= ASU_BAUD_RST;
      s_r.rx_sync <= 2'b11;
      s_r.txd <= 1'b1;
    end
    else if (pce)
      s_r <= s_nxt;
  end
endmodule // asu_core

// ---- tb/asu_core_sva.sv ----
// Checker for the serial core, bound to its ports.
// Assumes the pin option register stays at reset.
`timescale 1ns/1ps
module asu_core_sva
  import asu_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and events
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic rxd_sel,
  input wire logic rx_done,
  input wire logic tx_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mw = psel && penable && pwrite && paddr == ASU_OFF_MODE;
  ready_hi_a: assert property (pready) else $error("pready low");
  // Pin enables follow the mode register one clock after it is written
  mode_oe_a: assert property (mw |-> ##2 txd_oe == $past(pwdata[7], 2)) else $error("oe");
  mode_sel_a: assert property (mw && !pwdata[6] |-> ##2 !rxd_sel) else $error("sel");
  tx_read_a: assert property (psel && !penable && !pwrite && paddr == ASU_OFF_TX
    |=> prdata == 32'h0) else $error("tx read");
  rx_pulse_a: assert property (rx_done |=> !rx_done) else $error("rx pulse");
  tx_pulse_a: assert property (tx_done |=> !tx_done) else $error("tx pulse");
  start_low_a: assert property ($fell(txd) |-> !txd [*8]) else $error("start");
  idle_high_a: assert property (!txd_oe |-> txd) else $error("idle");
  stop_high_a: assert property (tx_done |-> txd) else $error("stop");
  cover property (rx_done);
  cover property (tx_done);
  cover property ($fell(rxd_sel));
endmodule // asu_core_sva

// ---- tb/asu_peer.sv ----
// Remote serial device: sends frames on rxd, decodes frames on txd.
// Assumes bit time of BIT clocks and 7 or 8 data bits.
`timescale 1ns/1ps
module asu_peer #(parameter int BIT = 512)
(
  input wire logic pclk,
  input wire logic txd,
  input wire logic len8,
  output logic rxd,
  output logic [7:0] got,
  output logic got_v
);
  int j;
  initial begin rxd = 1'b1; got_v = 1'b0; got = 8'h00; end
  task automatic send(input logic [7:0] b, input logic stop);
    int i;
    rxd <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (i = 0; i < 7 + len8; i++)
    begin
      rxd <= b[i];
      repeat (BIT) @(posedge pclk);
    end
    rxd <= stop;
    repeat (BIT) @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask
  always
  begin
    @(negedge txd);
    got = 8'h00;
    repeat (BIT * 3 / 2) @(posedge pclk);
    for (j = 0; j < 7 + len8; j++)
    begin
      got[j] = txd;
      repeat (BIT) @(posedge pclk);
    end
    // A missing stop bit poisons the character
    if (txd !== 1'b1) got = 8'hXX;
    got_v <= 1'b1;
    @(posedge pclk);
    got_v <= 1'b0;
  end
endmodule // asu_peer

// ---- tb/asu_core_tb.sv ----
// Bench for the serial core: APB master, remote peer, scoreboard.
// Assumes baud register 0 gives 512 clocks a bit.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module asu_core_tb;
  import asu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, len8 = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, rxd, txd, txd_oe, rxd_sel, rx_done, tx_done, got_v;
  logic [7:0] got, b, e;
  logic [7:0] q[$];
  int n_fail = 0, comparisons = 0, n_rx = 0, seed = 32'hae23, i, k;
  always #50 pclk = ~pclk;
  asu_core dut (.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .baud_clk_pin(1'b0), .txd,
    .txd_oe, .rxd_sel, .rx_done, .tx_done);
  asu_peer peer (.pclk, .txd, .len8, .rxd, .got, .got_v);
  always @(posedge pclk) if (rx_done === 1'b1) n_rx <= n_rx + 1;
  always @(posedge pclk)
  if (got_v === 1'b1)
  begin
    e = q.pop_front();
    `CHK("tx byte", e, got)
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input string n);
    apb(0, a, 0);
    `CHK(n, {24'h0, x}, r)
  endtask
  task automatic txb(input logic [7:0] d, input logic [7:0] x);
    q.push_back(x);
    wr(ASU_OFF_TX, d);
    wait (q.size() == 0);
    @(posedge pclk iff tx_done === 1'b1);
  endtask
  task automatic complete_run;
    $display("%0d compares, %0d bad", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin repeat (60000) @(posedge pclk); n_fail++; complete_run; end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(ASU_OFF_RX, ASU_RX_RST, "rx rst");
    rd(ASU_OFF_MODE, ASU_MODE_RST, "mode rst");
    rd(ASU_OFF_ERR, 8'h00, "err rst");
    rd(ASU_OFF_TX, 8'h00, "tx rd");
    rd(12'h0FC, 8'h00, "unmapped");
    wr(ASU_OFF_BAUD, 8'h00);
    wr(ASU_OFF_MODE, 8'hE0);
    repeat (2) @(posedge pclk);
    `CHK("pins on", 2'b11, {txd_oe, rxd_sel})
    $display("registers done");
    for (i = 0; i < 2; i++)
    begin
      b = $random(seed);
      fork peer.send(b, 1); txb(~b, ~b); join
      rd(ASU_OFF_RX, b, "rx byte");
    end
    `CHK("rx count", 2, n_rx)
    wr(ASU_OFF_RX, 8'h5A);
    rd(ASU_OFF_RX, b, "rx ro");
    wr(ASU_OFF_MODE, 8'hC0);
    len8 <= 0;
    b = $random(seed);
    fork peer.send(b, 1); txb(b, b & 8'h7F); join
    rd(ASU_OFF_RX, b & 8'h7F, "rx 7bit");
    len8 <= 1;
    $display("duplex done");
    for (i = 0; i < 2; i++)
    begin
      wr(ASU_OFF_MODE, {6'b111000, i[0], 1'b0});
      b = $random(seed);
      k = n_rx;
      peer.send(b, 0);
      `CHK("err irq", k + 1 - i, n_rx)
      rd(ASU_OFF_ERR, 8'h01, "frame err");
      rd(ASU_OFF_RX, b, "err data");
    end
    wr(ASU_OFF_PIN, 8'h01);
    repeat (2) @(posedge pclk);
    `CHK("pin opt", 2'b10, {txd_oe, rxd_sel})
    rd(ASU_OFF_PIN, 8'h01, "pin rd");
    wr(ASU_OFF_PIN, 8'h00);
    wr(ASU_OFF_MODE, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("pins off", 2'b00, {txd_oe, rxd_sel})
    $display("errors done");
    complete_run;
  end
endmodule // asu_core_tb
bind asu_core asu_core_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .txd, .txd_oe, .rxd_sel, .rx_done, .tx_done);
